// File: core/dbu_data_break.sv
// data breakpoint unit: channels, pass counters and avalon register slave
//
// Behaviour
// - eight-bit pass counter per instruction channel
// - nonzero count decrements, suppresses action
// - imprecise while count last written nonzero
// - instruction counter upper bits read zero
// - channel registers repeat every 0x100
// - status reports implemented channel count
// - match sets status bit, write zero clears
// - space identifier unsupported, reads zero
// - mask one excludes address bit
// - byte access ignore per lane, all four set drops lane check
// - store exclude blocks store matches
// - load exclude blocks load matches
// - exclusive bit selects outside range
// - range support preset, range mode select
// - byte lane mask excludes value lanes
// - trigger enable makes triggerpoint
// - invert value match inverts comparison
// - break enable makes breakpoint
// - per channel value register compared
// - space id use bit reads zero
// - sixteen-bit data pass counter per channel
// - precise load value break captures data
module dbu_data_break #(
   parameter int NUM_DCH = 4,
   parameter int NUM_ICH = 8
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   input  wire logic [15:0]          avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire dbu_pkg::dbu_access_t acc,
   input  wire dbu_pkg::dbu_imatch_t imatch,
   output logic [NUM_DCH-1:0]        data_break,
   output logic [NUM_DCH-1:0]        data_trigger,
   output logic                      data_imprecise,
   output logic [NUM_ICH-1:0]        instr_fire,
   output logic                      instr_imprecise
);
   initial
   begin
      if (!(NUM_DCH == 0 || NUM_DCH == 1 || NUM_DCH == 2 || NUM_DCH == 4))
         $error("NUM_DCH must be 0, 1, 2 or 4");
      if (NUM_ICH < 1 || NUM_ICH > 8)
         $error("NUM_ICH must be 1 to 8");
   end

   localparam int DC = (NUM_DCH == 0) ? 1 : NUM_DCH;
   localparam logic [3:0] CNT_CODE = 4'(NUM_DCH);

   // ========================================
   // state
   logic [31:0]             dba_ff  [DC];
   logic [31:0]             dbm_ff  [DC];
   logic [31:0]             dbv_ff  [DC];
   dbu_pkg::dbu_ctl_t       dbc_ff  [DC];
   logic [15:0]             dpc_ff  [DC];
   logic [DC-1:0]           dimp_ff;
   logic [7:0]              ipc_ff  [NUM_ICH];
   logic [NUM_ICH-1:0]      iimp_ff;
   logic [3:0]              bs_ff;
   logic [31:0]             dvc_ff;
   logic                    ack_ff;
   logic [31:0]             nxt_rdata;
   logic [DC-1:0]           hit;

   // ========================================
   // decode helpers
   function automatic logic [15:0] ch_base(input logic [15:0] a);
      ch_base = (a & dbu_pkg::CH_OFS_MASK) | (a & ~dbu_pkg::CH_SEL_MASK & 16'h0000);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      for (int b = 0; b < 4; b++)
         merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
   endfunction

   logic [3:0]  dsel;
   logic [15:0] dreg;
   logic        in_dch;
   logic [3:0]  isel;
   logic        in_ich;
   logic        wr_go;
   logic [31:0] wmerge_ctl;

   always_comb
   begin
      dsel   = 4'(avs_address[11:8] - 4'h1);
      dreg   = {8'h00, avs_address[7:0]} | 16'h2000 | 16'h0100;
      in_dch = (avs_address[15:12] == 4'h2) && (avs_address[11:8] != 4'h0)
               && (avs_address[11:8] <= 4'(NUM_DCH)) && (avs_address[11:8] != 4'hf);
      isel   = 4'(avs_address[11:8] - 4'h1);
      in_ich = (avs_address[15:12] == 4'h1) && (avs_address[7:0] == 8'h28)
               && (avs_address[11:8] != 4'h0) && (avs_address[11:8] <= 4'(NUM_ICH));
      wr_go  = avs_write && ack_ff;
      wmerge_ctl = avs_writedata;
   end

   // ========================================
   // match logic
   always_comb
   begin
      for (int c = 0; c < DC; c++)
      begin
         logic am;
         logic lane_ok;
         logic vm;
         logic [31:0] lo;
         logic [31:0] hi;
         logic [31:0] lmask;
         am = 1'b0;
         lane_ok = 1'b0;
         vm = 1'b0;
         lo = dba_ff[c];
         hi = dba_ff[c] | dbm_ff[c];
         lmask = 32'h0;
         if (dbc_ff[c].hwart)
            am = (acc.addr >= lo) && (acc.addr <= hi);
         else
            am = ((acc.addr ^ dba_ff[c]) & ~dbm_ff[c]) == 32'h0;
         am = am ^ dbc_ff[c].excl;
         lane_ok = |(acc.lanes & ~dbc_ff[c].byte_access_ignore) || (&dbc_ff[c].byte_access_ignore);
         for (int b = 0; b < 4; b++)
            lmask[b*8 +: 8] = {8{~dbc_ff[c].byte_lane_mask[b] & acc.lanes[b]}};
         vm = ((acc.data ^ dbv_ff[c]) & lmask) == 32'h0;
         vm = vm ^ dbc_ff[c].invert_value_match;
         hit[c] = acc.valid && am && lane_ok && vm && (c < NUM_DCH)
                  && !(acc.store && dbc_ff[c].store_exclude)
                  && !(!acc.store && dbc_ff[c].load_exclude);
      end
   end

   // ========================================
   // data channel registers and pass counters
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < DC; c++)
         begin
            dba_ff[c] <= dbu_pkg::RST_ZERO;
            dbm_ff[c] <= dbu_pkg::RST_ZERO;
            dbv_ff[c] <= dbu_pkg::RST_ZERO;
            dbc_ff[c] <= '0;
            dpc_ff[c] <= 16'h0000;
         end
         dimp_ff      <= '0;
         data_break   <= '0;
         data_trigger <= '0;
         data_imprecise <= 1'b0;
      end
      else
      begin
         data_imprecise <= 1'b0;
         for (int c = 0; c < DC; c++)
         begin
            logic fire;
            fire = hit[c] && (dpc_ff[c] == 16'h0000);
            if (hit[c] && dpc_ff[c] != 16'h0000)
               dpc_ff[c] <= 16'(dpc_ff[c] - 16'h0001);
            data_break[c]   <= fire && dbc_ff[c].be;
            data_trigger[c] <= fire && dbc_ff[c].te;
            if (fire && dimp_ff[c] && (dbc_ff[c].be || dbc_ff[c].te))
               data_imprecise <= 1'b1;
         end
         if (wr_go && in_dch)
         begin
            unique case (avs_address[7:0])
               dbu_pkg::OFS_DBA0[7:0]:
                  dba_ff[dsel[1:0]] <= merge(dba_ff[dsel[1:0]], avs_writedata, avs_byteenable);
               dbu_pkg::OFS_DBM0[7:0]:
                  dbm_ff[dsel[1:0]] <= merge(dbm_ff[dsel[1:0]], avs_writedata, avs_byteenable);
               dbu_pkg::OFS_DBV0[7:0]:
                  dbv_ff[dsel[1:0]] <= merge(dbv_ff[dsel[1:0]], avs_writedata, avs_byteenable);
               dbu_pkg::OFS_DBC0[7:0]:
               begin
                  dbc_ff[dsel[1:0]].byte_access_ignore   <= wmerge_ctl[dbu_pkg::DBC_BAI_LSB +: 4];
                  dbc_ff[dsel[1:0]].store_exclude  <= wmerge_ctl[dbu_pkg::DBC_STORE_EXCLUDE_BIT];
                  dbc_ff[dsel[1:0]].load_exclude  <= wmerge_ctl[dbu_pkg::DBC_LOAD_EXCLUDE_BIT];
                  dbc_ff[dsel[1:0]].excl  <= wmerge_ctl[dbu_pkg::DBC_EXCL_BIT];
                  dbc_ff[dsel[1:0]].hwart <= wmerge_ctl[dbu_pkg::DBC_HWRT_BIT];
                  dbc_ff[dsel[1:0]].byte_lane_mask   <= wmerge_ctl[dbu_pkg::DBC_BLM_LSB +: 4];
                  dbc_ff[dsel[1:0]].te    <= wmerge_ctl[dbu_pkg::DBC_TE_BIT];
                  dbc_ff[dsel[1:0]].invert_value_match   <= wmerge_ctl[dbu_pkg::DBC_IVM_BIT];
                  dbc_ff[dsel[1:0]].be    <= wmerge_ctl[dbu_pkg::DBC_BE_BIT];
               end
               dbu_pkg::OFS_DBPC0[7:0]:
               begin
                  dpc_ff[dsel[1:0]]  <= avs_writedata[15:0];
                  dimp_ff[dsel[1:0]] <= |avs_writedata[15:0];
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // ========================================
   // instruction pass counters
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_ICH; i++)
            ipc_ff[i] <= 8'h00;
         iimp_ff         <= '0;
         instr_fire      <= '0;
         instr_imprecise <= 1'b0;
      end
      else
      begin
         instr_fire      <= '0;
         instr_imprecise <= 1'b0;
         if (imatch.valid && 32'(imatch.chan) < NUM_ICH)
         begin
            if (ipc_ff[imatch.chan] != 8'h00)
               ipc_ff[imatch.chan] <= 8'(ipc_ff[imatch.chan] - 8'h01);
            else
            begin
               instr_fire[imatch.chan] <= 1'b1;
               instr_imprecise <= iimp_ff[imatch.chan];
            end
         end
         if (wr_go && in_ich)
         begin
            ipc_ff[isel[2:0]]  <= avs_writedata[7:0];
            iimp_ff[isel[2:0]] <= |avs_writedata[7:0];
         end
      end
   end

   // ========================================
   // status bits and load value capture
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bs_ff  <= dbu_pkg::RST_NIB;
         dvc_ff <= dbu_pkg::RST_ZERO;
      end
      else
      begin
         logic [3:0] clr;
         logic [3:0] set;
         clr = '0;
         set = '0;
         for (int c = 0; c < DC; c++)
            set[c] = hit[c];
         if (wr_go && avs_address == dbu_pkg::OFS_DBS && avs_byteenable[0])
            clr = ~avs_writedata[3:0];
         bs_ff <= ((bs_ff & ~clr) | set) & 4'((1 << NUM_DCH) - 1);
         for (int c = 0; c < DC; c++)
            if (hit[c] && dpc_ff[c] == 16'h0000 && !dimp_ff[c] && !acc.store
                && dbc_ff[c].be && dbc_ff[c].byte_lane_mask != 4'hf)
               dvc_ff <= acc.data;
      end
   end

   // ========================================
   // avalon read mux
   always_comb
   begin
      nxt_rdata = 32'h0;
      if (avs_address == dbu_pkg::OFS_DBS)
         nxt_rdata = {4'h0, CNT_CODE, 20'h0, bs_ff};
      else if (avs_address == dbu_pkg::OFS_DVC)
         nxt_rdata = dvc_ff;
      else if (in_ich)
         nxt_rdata = {24'h0, ipc_ff[isel[2:0]]};
      else if (in_dch)
      begin
         unique case (avs_address[7:0])
            dbu_pkg::OFS_DBA0[7:0]: nxt_rdata = dba_ff[dsel[1:0]];
            dbu_pkg::OFS_DBM0[7:0]: nxt_rdata = dbm_ff[dsel[1:0]];
            dbu_pkg::OFS_DBV0[7:0]: nxt_rdata = dbv_ff[dsel[1:0]];
            dbu_pkg::OFS_DBC0[7:0]:
               nxt_rdata = {8'h0, 1'b0, 5'h0, dbc_ff[dsel[1:0]].byte_access_ignore,
                            dbc_ff[dsel[1:0]].store_exclude, dbc_ff[dsel[1:0]].load_exclude, 1'b0,
                            1'b1, dbc_ff[dsel[1:0]].excl,
                            dbc_ff[dsel[1:0]].hwart, dbc_ff[dsel[1:0]].byte_lane_mask, 1'b0,
                            dbc_ff[dsel[1:0]].te, dbc_ff[dsel[1:0]].invert_value_match,
                            dbc_ff[dsel[1:0]].be};
            dbu_pkg::OFS_DBPC0[7:0]: nxt_rdata = {16'h0, dpc_ff[dsel[1:0]]};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   // ========================================
   // avalon handshake: one wait cycle per access
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_ff          <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= dbu_pkg::RST_ZERO;
      end
      else
      begin
         ack_ff          <= (avs_read || avs_write) && !ack_ff;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
         if (avs_read && !ack_ff)
            avs_readdata <= nxt_rdata;
      end
   end

   logic unused_ok;
   assign unused_ok = ^{ch_base(avs_address), dreg, dbu_pkg::CH_STRIDE};
endmodule

// File: core/dbu_pkg.sv
// package: register map, field layout and carriers of the data breakpoint unit
package dbu_pkg;
   // ========================================
   // register offsets (byte addresses)
   localparam logic [15:0] OFS_IBPC0   = 16'h1128;
   localparam logic [15:0] OFS_DBS     = 16'h2000;
   localparam logic [15:0] OFS_DBA0    = 16'h2100;
   localparam logic [15:0] OFS_DBM0    = 16'h2108;
   localparam logic [15:0] OFS_DBSID0  = 16'h2110;
   localparam logic [15:0] OFS_DBC0    = 16'h2118;
   localparam logic [15:0] OFS_DBV0    = 16'h2120;
   localparam logic [15:0] OFS_DBCC0   = 16'h2128;
   localparam logic [15:0] OFS_DBPC0   = 16'h2130;
   localparam logic [15:0] OFS_DVC     = 16'h2ff0;
   localparam logic [15:0] CH_STRIDE   = 16'h0100;
   localparam logic [15:0] CH_OFS_MASK = 16'h00ff;
   localparam logic [15:0] CH_SEL_MASK = 16'hff00;
   // ========================================
   // field positions
   localparam int DBS_CNT_LSB  = 24;
   localparam int DBC_SIDU_BIT = 23;
   localparam int DBC_BAI_LSB  = 14;
   localparam int DBC_STORE_EXCLUDE_BIT = 13;
   localparam int DBC_LOAD_EXCLUDE_BIT = 12;
   localparam int DBC_RNG_BIT  = 10;
   localparam int DBC_EXCL_BIT = 9;
   localparam int DBC_HWRT_BIT = 8;
   localparam int DBC_BLM_LSB  = 4;
   localparam int DBC_TE_BIT   = 2;
   localparam int DBC_IVM_BIT  = 1;
   localparam int DBC_BE_BIT   = 0;
   localparam int IPC_W        = 8;
   localparam int DPC_W        = 16;
   // ========================================
   // reset values
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [3:0]  RST_NIB     = 4'h0;
   localparam logic [31:0] ALL_ONES    = 32'hffff_ffff;

   typedef struct packed {
      logic [3:0] byte_access_ignore;
      logic       store_exclude;
      logic       load_exclude;
      logic       excl;
      logic       hwart;
      logic [3:0] byte_lane_mask;
      logic       te;
      logic       invert_value_match;
      logic       be;
   } dbu_ctl_t;

   // one access of the load/store pipeline
   typedef struct packed {
      logic        valid;
      logic        store;
      logic [31:0] addr;
      logic [3:0]  lanes;
      logic [31:0] data;
   } dbu_access_t;

   // one instruction breakpoint match event
   typedef struct packed {
      logic       valid;
      logic [2:0] chan;
   } dbu_imatch_t;
endpackage

// File: verif/dbu_data_break_props.sv
// checker: bus handshake, fixed read fields and match output causes
module dbu_data_break_props #(
   parameter int NUM_DCH = 4,
   parameter int NUM_ICH = 8
) (
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire logic [15:0]          avs_address,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic [31:0]          avs_writedata,
   input wire logic [3:0]           avs_byteenable,
   input wire logic [31:0]          avs_readdata,
   input wire logic                 avs_waitrequest,
   input wire dbu_pkg::dbu_access_t acc,
   input wire dbu_pkg::dbu_imatch_t imatch,
   input wire logic [NUM_DCH-1:0]   data_break,
   input wire logic [NUM_DCH-1:0]   data_trigger,
   input wire logic                 data_imprecise,
   input wire logic [NUM_ICH-1:0]   instr_fire,
   input wire logic                 instr_imprecise
);
   // ========================================
   // helpers
   logic rd_ack;
   logic dch_hit;
   assign rd_ack  = avs_read && !avs_waitrequest;
   assign dch_hit = (avs_address[15:8] > 8'h20) && (avs_address[15:8] <= 8'(8'h20 + NUM_DCH));
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ========================================
   // assertions
   AST_ACK_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait");
   AST_ACK_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_ACK_HAS_REQ: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("answer without request");
   AST_IPC_UPPER: assert property (rd_ack && avs_address == dbu_pkg::OFS_IBPC0 |->
      avs_readdata[31:8] == 24'h00_0000) else $error("pass count upper bits not zero");
   AST_DBS_COUNT: assert property (rd_ack && avs_address == dbu_pkg::OFS_DBS |->
      avs_readdata[31:4] == {4'h0, 4'(NUM_DCH), 20'h0_0000}) else $error("status fixed fields wrong");
   AST_SID_ZERO: assert property (rd_ack && dch_hit && avs_address[7:0] == 8'h10 |->
      avs_readdata == 32'h0000_0000) else $error("space id register not zero");
   AST_CTL_FIXED: assert property (rd_ack && dch_hit && avs_address[7:0] == 8'h18 |->
      avs_readdata[31:18] == 14'h0000 && avs_readdata[11:10] == 2'h1 && !avs_readdata[3])
      else $error("control fixed bits wrong");
   AST_DPC_UPPER: assert property (rd_ack && dch_hit && avs_address[7:0] == 8'h30 |->
      avs_readdata[31:16] == 16'h0000) else $error("data pass count upper bits not zero");
   AST_DATA_CAUSE: assert property ((data_break | data_trigger) != '0 |-> $past(acc.valid))
      else $error("data action without access");
   AST_INSTR_CAUSE: assert property (instr_fire != '0 |-> $past(imatch.valid) &&
      instr_fire == (1 << $past(imatch.chan))) else $error("instruction fire without match");
   AST_IMPRECISE: assert property (data_imprecise |-> (data_break | data_trigger) != '0)
      else $error("imprecise without action");
endmodule

bind dbu_data_break dbu_data_break_props #(.NUM_DCH(NUM_DCH), .NUM_ICH(NUM_ICH)) i_dbu_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc(acc), .imatch(imatch),
   .data_break(data_break), .data_trigger(data_trigger), .data_imprecise(data_imprecise),
   .instr_fire(instr_fire), .instr_imprecise(instr_imprecise));

// File: verif/dbu_data_break_tb.sv
// testbench of the data breakpoint unit
module dbu_data_break_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, g, w); end end
   localparam logic [17:0] NONE = 18'h0_0000;
   localparam logic [17:0] BRK0 = 18'h0_4000;
   localparam logic [17:0] TRG0 = 18'h0_0400;
   localparam logic [17:0] DIMP = 18'h0_0200;
   localparam logic [17:0] IF0  = 18'h0_0002;
   localparam logic [17:0] IIMP = 18'h0_0001;
   logic                 ref_clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic [15:0]          avs_address = 16'h0000;
   logic                 avs_read = 1'b0;
   logic                 avs_write = 1'b0;
   logic [31:0]          avs_writedata = 32'h0000_0000;
   logic [3:0]           avs_byteenable = 4'hf;
   logic [31:0]          avs_readdata;
   logic                 avs_waitrequest;
   dbu_pkg::dbu_access_t acc;
   dbu_pkg::dbu_imatch_t imatch;
   logic [3:0]           data_break;
   logic [3:0]           data_trigger;
   logic                 data_imprecise;
   logic [7:0]           instr_fire;
   logic                 instr_imprecise;
   logic [31:0]          rd_q[$];
   logic [17:0]          ev_q[$];
   logic                 pend = 1'b0;
   logic [31:0]          rv;
   int                   mismatches = 0;
   int                   checks_done = 0;

   dbu_data_break i_dbu_data_break (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .acc(acc), .imatch(imatch), .data_break(data_break),
      .data_trigger(data_trigger), .data_imprecise(data_imprecise), .instr_fire(instr_fire),
      .instr_imprecise(instr_imprecise));
   dbu_lsu_model i_dbu_lsu_model (.ref_clk(ref_clk), .acc(acc), .imatch(imatch));

   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end
   // ========================================
   // monitor: oldest note against each result
   always @(posedge ref_clk)
   begin
      if (avs_read && avs_waitrequest === 1'b0)
         `CHK(avs_readdata, rd_q.pop_front())
      if (pend)
         `CHK({data_break, data_trigger, data_imprecise, instr_fire, instr_imprecise}, ev_q.pop_front())
      pend = acc.valid || imatch.valid;
   end
   // ========================================
   // tasks
   task automatic complete_run();
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         mismatches++;
         complete_run();
      end
      else
      begin
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         avs_writedata <= ~d;
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic ev(input logic st, input logic [31:0] a, input logic [3:0] l,
                     input logic [31:0] d, input logic [17:0] e);
      ev_q.push_back(e);
      i_dbu_lsu_model.do_acc(st, a, l, d);
   endtask
   task automatic mc(input logic [31:0] c, input logic st, input logic [31:0] a,
                     input logic [3:0] l, input logic [31:0] d, input logic [17:0] e);
      bus(1'b1, dbu_pkg::OFS_DBC0, c);
      ev(st, a, l, d, e);
   endtask
   task automatic im(input logic [2:0] ch, input logic [17:0] e);
      ev_q.push_back(e);
      i_dbu_lsu_model.do_imatch(ch);
   endtask
   // ========================================
   // main sequence
   initial
   begin
      rv = $urandom(32'hebbfe649);
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(dbu_pkg::OFS_DBS, 32'h0400_0000);
      rd(dbu_pkg::OFS_DBC0, 32'h0000_0400);
      rd(dbu_pkg::OFS_IBPC0, 32'h0000_0000);
      bus(1'b1, dbu_pkg::OFS_DBC0 + dbu_pkg::CH_STRIDE, 32'h0003_f3f7);
      rd(dbu_pkg::OFS_DBC0 + dbu_pkg::CH_STRIDE, 32'h0003_f7f7);
      bus(1'b1, dbu_pkg::OFS_DBSID0, 32'h0000_00ff);
      rd(dbu_pkg::OFS_DBSID0, 32'h0000_0000);
      bus(1'b1, 16'h3000, rv);
      rd(16'h3000, 32'h0000_0000);
      bus(1'b1, 16'h2220, ~rv);
      rd(16'h2220, ~rv);
      bus(1'b1, dbu_pkg::OFS_DBA0, 32'h0000_1000);
      bus(1'b1, dbu_pkg::OFS_DBM0, 32'h0000_000f);
      bus(1'b1, dbu_pkg::OFS_DBV0, rv);
      mc(32'h0000_0001, 1'b0, 32'h0000_1004, 4'hf, rv, BRK0);
      mc(32'h0000_0001, 1'b0, 32'h0000_1010, 4'hf, rv, NONE);
      mc(32'h0000_1001, 1'b0, 32'h0000_1000, 4'hf, rv, NONE);
      mc(32'h0000_1001, 1'b1, 32'h0000_1000, 4'hf, rv, BRK0);
      mc(32'h0000_2001, 1'b1, 32'h0000_1000, 4'hf, rv, NONE);
      mc(32'h0000_0004, 1'b0, 32'h0000_1000, 4'hf, rv, TRG0);
      mc(32'h0000_0003, 1'b0, 32'h0000_1000, 4'hf, ~rv, BRK0);
      mc(32'h0000_0003, 1'b0, 32'h0000_1000, 4'hf, rv, NONE);
      mc(32'h0000_00f1, 1'b0, 32'h0000_1000, 4'hf, ~rv, BRK0);
      mc(32'h0000_0001, 1'b0, 32'h0000_1000, 4'hf, ~rv, NONE);
      mc(32'h0000_0301, 1'b0, 32'h0000_2000, 4'hf, rv, BRK0);
      mc(32'h0000_0301, 1'b0, 32'h0000_1008, 4'hf, rv, NONE);
      mc(32'h0000_0101, 1'b0, 32'h0000_100f, 4'hf, rv, BRK0);
      mc(32'h0003_c001, 1'b0, 32'h0000_1000, 4'h0, rv, BRK0);
      mc(32'h0000_0001, 1'b0, 32'h0000_1000, 4'h0, rv, NONE);
      rd(dbu_pkg::OFS_DBS, 32'h0400_0001);
      bus(1'b1, dbu_pkg::OFS_DBS, 32'h0000_0000);
      rd(dbu_pkg::OFS_DBS, 32'h0400_0000);
      bus(1'b1, dbu_pkg::OFS_DBPC0, 32'h0001_0002);
      rd(dbu_pkg::OFS_DBPC0, 32'h0000_0002);
      repeat (2) ev(1'b0, 32'h0000_1000, 4'hf, rv, NONE);
      ev(1'b0, 32'h0000_1000, 4'hf, rv, BRK0 | DIMP);
      bus(1'b1, dbu_pkg::OFS_DBPC0, 32'h0000_0000);
      ev(1'b0, 32'h0000_1000, 4'hf, rv, BRK0);
      rd(dbu_pkg::OFS_DVC, rv);
      bus(1'b1, dbu_pkg::OFS_IBPC0, 32'hffff_ff01);
      rd(dbu_pkg::OFS_IBPC0, 32'h0000_0001);
      im(3'h0, NONE);
      im(3'h0, IF0 | IIMP);
      bus(1'b1, dbu_pkg::OFS_IBPC0, 32'h0000_0000);
      im(3'h0, IF0);
      im(3'h3, 18'h0_0010);
      repeat (3) @(posedge ref_clk);
      complete_run();
   end
endmodule

// File: verif/dbu_lsu_model.sv
// model of the load/store pipeline and instruction match source
module dbu_lsu_model (
   input wire logic            ref_clk,
   output dbu_pkg::dbu_access_t acc,
   output dbu_pkg::dbu_imatch_t imatch
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      acc = '0;
      imatch = '0;
   end
   // one access cycle, fields inverted once released
   task automatic do_acc(input logic st, input logic [31:0] a, input logic [3:0] l,
                         input logic [31:0] d);
      @(posedge ref_clk);
      acc <= {1'b1, st, a, l, d};
      @(posedge ref_clk);
      acc <= {1'b0, ~st, ~a, ~l, ~d};
   endtask
   task automatic do_imatch(input logic [2:0] ch);
      @(posedge ref_clk);
      imatch <= {1'b1, ch};
      @(posedge ref_clk);
      imatch <= {1'b0, ~ch};
   endtask
endmodule
